// ===== rtl/oag_core.sv
/*
  oag_core: operand address and immediate generation for a 20-bit CPU
  with base and extended double-operand instructions.
  Assumes decode presents one request at a time with a valid pulse,
  memory answers every read combinationally from MEM.addr with MEM_RDATA, and
  register file reads are combinational through REG_RADDR/REG_RDATA.
*/
`timescale 1ns/1ps
`default_nettype none

module oag_core
  import oag_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // request from decode
  input wire logic REQ_VALID,
  input wire oag_req_t REQ,
  input wire logic [19:0] PC_IN,
  output logic REQ_READY,
  // register file
  output logic [3:0] REG_RADDR,
  input wire logic [19:0] REG_RDATA,
  // memory
  output oag_mem_t MEM,
  input wire logic [15:0] MEM_RDATA,
  // result
  output logic RES_VALID,
  output oag_res_t RES
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SRCW = 5'b00010,
    ST_SRCD = 5'b00100,
    ST_DSTW = 5'b01000,
    ST_DONE = 5'b10000
  } oag_st_t;

  oag_st_t st_r, st_nxt;
  oag_req_t req_r;
  logic [19:0] pc_r;
  logic [19:0] ptr_r;
  oag_res_t res_r;
  logic res_v_r;

  //////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] step_of(input logic [1:0] sz);
    unique case (sz)
      SZ_BYTE: step_of = INC_BYTE;
      SZ_WORD: step_of = INC_WORD;
      default: step_of = INC_ADDR;
    endcase
  endfunction

  // upper extension bits joined to a fetched word, or zero-extended
  function automatic logic [19:0] join_ext(input logic ext,
                                           input logic [3:0] hi,
                                           input logic [15:0] lo);
    join_ext = ext ? {hi, lo} : {4'h0, lo};
  endfunction

  // byte data keeps 8 bits, other base data 16; extended address-word keeps 20
  function automatic logic [19:0] clip(input logic ext,
                                       input logic [1:0] sz,
                                       input logic [19:0] v);
    if (ext && sz == SZ_ADDR)
      clip = v;
    else if (sz == SZ_BYTE)
      clip = {12'h000, v[7:0]};
    else
      clip = {4'h0, v[15:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////
  logic src_fetch;
  logic src_is_ptr;
  assign src_fetch = (req_r.src_am == AM_ABS) ||
                     (req_r.src_am == AM_IMM && !req_r.cg);
  assign src_is_ptr = (req_r.src_am == AM_IND) ||
                      (req_r.src_am == AM_AUTO);

  assign REQ_READY = (st_r == ST_IDLE);
  assign REG_RADDR = (st_r == ST_DONE) ? req_r.dst_reg : req_r.src_reg;

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:
        if (REQ_VALID)
          st_nxt = ST_SRCW;
      ST_SRCW:
        st_nxt = src_fetch ? ST_SRCD : (req_r.dst_abs ? ST_DSTW : ST_DONE);
      ST_SRCD:
        st_nxt = req_r.dst_abs ? ST_DSTW : ST_DONE;
      ST_DSTW:
        st_nxt = ST_DONE;
      ST_DONE:
        st_nxt = ST_IDLE;
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      req_r <= '0;
    else if (st_r == ST_IDLE && REQ_VALID)
      req_r <= REQ;
  end

  //////////////////////////////////////////////////////////////////////
  // program counter walks over following words; extension word is
  // already counted by fetch, so PC_IN points past the opcode
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      pc_r <= ADDR_ZERO;
    else if (st_r == ST_IDLE && REQ_VALID)
      pc_r <= PC_IN;
    else if ((st_r == ST_SRCW && src_fetch) || st_r == ST_DSTW)
      pc_r <= pc_r + INC_PC;
  end

  // memory read of the next following word
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      MEM <= '0;
    else
    begin
      MEM.wr <= 1'b0;
      MEM.wdata <= DATA_ZERO;
      MEM.rd <= (st_nxt == ST_SRCD) || (st_nxt == ST_DONE && st_r == ST_DSTW)
                || (st_nxt == ST_DSTW && st_r != ST_DSTW);
      MEM.addr <= pc_r;
      if (st_r == ST_SRCW && src_fetch)
        MEM.addr <= pc_r;
      else if (st_r == ST_SRCD || (st_r == ST_SRCW && !src_fetch))
        MEM.addr <= (st_r == ST_SRCD) ? pc_r : pc_r;
      if (st_nxt == ST_DONE)
        MEM.rd <= 1'b0;
    end
  end

  // pointer capture for indirect modes; the increment is formed in the result logic
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      ptr_r <= ADDR_ZERO;
    else if (st_r == ST_SRCW && src_is_ptr)
      ptr_r <= REG_RDATA;
  end

  //////////////////////////////////////////////////////////////////////
  logic [19:0] src_word;
  assign src_word = join_ext(req_r.ext, req_r.src_ext, MEM_RDATA);

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      res_r <= '0;
      res_v_r <= 1'b0;
    end
    else
    begin
      res_v_r <= (st_r == ST_DONE);
      if (st_r == ST_IDLE && REQ_VALID)
      begin
        res_r <= '0;
        // extension word present costs one more word
        res_r.words <= REQ.ext ? 3'd2 : 3'd1;
      end
      if (st_r == ST_SRCW && req_r.src_am == AM_IMM && req_r.cg)
      begin
        res_r.src_is_imm <= 1'b1;
        res_r.src_val <= clip(req_r.ext, req_r.sz, req_r.cg_val);
      end
      if (st_r == ST_SRCD)
      begin
        res_r.words <= res_r.words + 3'd1;
        if (req_r.src_am == AM_IMM)
        begin
          res_r.src_is_imm <= 1'b1;
          res_r.src_val <= clip(req_r.ext, req_r.sz, src_word);
        end
        else
          res_r.src_addr <= src_word;
      end
      if (st_r == ST_SRCW && src_is_ptr)
      begin
        res_r.src_addr <= REG_RDATA;
        if (req_r.src_am == AM_AUTO)
        begin
          res_r.inc_we <= 1'b1;
          res_r.inc_reg <= req_r.src_reg;
          res_r.inc_val <= REG_RDATA + step_of(req_r.sz);
        end
      end
      if (st_r == ST_DONE && st_r != ST_DSTW && req_r.dst_abs)
      begin
        res_r.words <= res_r.words + 3'd1;
        res_r.dst_addr <= join_ext(req_r.ext, req_r.dst_ext,
                                   MEM_RDATA);
      end
      if (st_r == ST_DONE)
      begin
        res_r.pc <= pc_r;
        // destination base register, already incremented when shared
        if (req_r.src_am == AM_AUTO && req_r.dst_reg == req_r.src_reg)
          res_r.dst_base <= ptr_r + step_of(req_r.sz);
        else
          res_r.dst_base <= REG_RDATA;
      end
    end
  end

  assign RES_VALID = res_v_r;
  // address-word operand spans addr and addr + HI_WORD_OFS, low first
  assign RES = res_r;

endmodule

`default_nettype wire

// ===== shared/oag_pkg.sv
/*
  oag_pkg: constants and carrier types for the operand address
  generator. Assumes a 20-bit address space and 16-bit memory words.
*/
package oag_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned EXT_W = 4;

  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_ADDR = 2'h2;

  // autoincrement steps per size, and the fixed program counter step
  localparam logic [19:0] INC_BYTE = 20'h0_0001;
  localparam logic [19:0] INC_WORD = 20'h0_0002;
  localparam logic [19:0] INC_ADDR = 20'h0_0004;
  localparam logic [19:0] INC_PC = 20'h0_0002;
  // second word of an address-word operand
  localparam logic [19:0] HI_WORD_OFS = 20'h0_0002;
  localparam logic [19:0] ADDR_ZERO = 20'h0_0000;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // operand addressing modes handled here
  localparam logic [1:0] AM_ABS = 2'h0;
  localparam logic [1:0] AM_IND = 2'h1;
  localparam logic [1:0] AM_AUTO = 2'h2;
  localparam logic [1:0] AM_IMM = 2'h3;

  typedef struct packed {
    logic ext;          // extended instruction (extension word present)
    logic [1:0] sz;     // SZ_*
    logic [1:0] src_am; // AM_* for source
    logic dst_abs;      // destination uses absolute mode
    logic cg;           // constant generator supplies the immediate
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    logic [3:0] src_ext; // upper source bits from extension word
    logic [3:0] dst_ext; // upper destination bits from extension word
    logic [19:0] cg_val;
  } oag_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [19:0] addr;
    logic [15:0] wdata;
  } oag_mem_t;

  typedef struct packed {
    logic src_is_imm;
    logic [19:0] src_addr;
    logic [19:0] src_val;
    logic [19:0] dst_addr;
    logic [19:0] dst_base;
    logic [3:0] inc_reg;
    logic inc_we;
    logic [19:0] inc_val;
    logic [19:0] pc;
    logic [2:0] words;
  } oag_res_t;

endpackage

// ===== tb/oag_props.sv
/*
  oag_props: port assertions for oag_core.
  assumes bind onto oag_core, one request in flight at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module oag_props
  import oag_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // request side
  input wire logic REQ_VALID,
  input wire oag_req_t REQ,
  input wire logic [19:0] PC_IN,
  input wire logic REQ_READY,
  // memory and result
  input wire oag_mem_t MEM,
  input wire logic RES_VALID,
  input wire oag_res_t RES
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  oag_req_t q_r;
  logic [19:0] step;
  logic take;
  assign take = REQ_VALID && REQ_READY;
  always_comb
    step = (q_r.sz == SZ_BYTE) ? INC_BYTE
         : (q_r.sz == SZ_WORD) ? INC_WORD : INC_ADDR;
  // the request is held aside so results can be judged against it
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
      q_r <= '0;
    else if (take)
      q_r <= REQ;
  AST_NO_WRITE: assert property (!MEM.wr)
    else $error("memory write seen");
  AST_BUSY: assert property (take |=> !REQ_READY)
    else $error("ready high right after take");
  AST_LATENCY: assert property (take |-> ##[3:5] RES_VALID)
    else $error("no result within five cycles");
  AST_PULSE: assert property (RES_VALID |=> !RES_VALID)
    else $error("result valid longer than one cycle");
  AST_IND_KEEP: assert property
    (RES_VALID && q_r.src_am == AM_IND |-> !RES.inc_we)
    else $error("indirect register modified");
  AST_AUTO_STEP: assert property
    (RES_VALID && q_r.src_am == AM_AUTO
     |-> RES.inc_we && RES.inc_val == RES.src_addr + step)
    else $error("autoincrement step wrong");
  AST_SHARED: assert property
    (RES_VALID && q_r.src_am == AM_AUTO && q_r.src_reg == q_r.dst_reg
     |-> RES.dst_base == RES.inc_val)
    else $error("shared register not incremented for destination");
  AST_ABS_HI: assert property
    (RES_VALID && q_r.src_am == AM_ABS && q_r.ext
     |-> RES.src_addr[19:16] == q_r.src_ext)
    else $error("absolute upper bits wrong");
  AST_CG: assert property
    (RES_VALID && q_r.src_am == AM_IMM && q_r.cg
     |-> RES.src_val == q_r.cg_val)
    else $error("constant generator value not used");
endmodule
`default_nettype wire

// ===== tb/testbench.sv
/*
  testbench: directed scenarios for oag_core.
  assumes the bench models register file and combinational memory.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import oag_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic REQ_VALID = 1'b0;
  oag_req_t REQ = '0;
  logic [19:0] PC_IN = 20'h0_0000;
  logic REQ_READY;
  logic [3:0] REG_RADDR;
  logic [19:0] REG_RDATA;
  oag_mem_t MEM;
  logic [15:0] MEM_RDATA;
  logic RES_VALID;
  oag_res_t RES;
  int num_errors = 0;
  int n_tests = 0;
  always #10 CLK_SYS = ~CLK_SYS;
  // register n reads as {n, 579C}; memory word reads as inverted address
  assign REG_RDATA = {REG_RADDR, 16'h579C};
  // the core registers the address one cycle ahead and samples the word
  // at the end of the cycle in which that address stands
  assign MEM_RDATA = ~MEM.addr[15:0];
  oag_core DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .PC_IN(PC_IN), .REQ_READY(REQ_READY),
    .REG_RADDR(REG_RADDR), .REG_RDATA(REG_RDATA), .MEM(MEM),
    .MEM_RDATA(MEM_RDATA), .RES_VALID(RES_VALID), .RES(RES));
  task automatic check(input string nm, input logic [19:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic issue(input oag_req_t r, input logic [19:0] pc);
    int n;
    n = 0;
    while (REQ_READY !== 1'b1 && n < 20)
    begin
      @(negedge CLK_SYS);
      n++;
    end
    @(posedge CLK_SYS);
    REQ_VALID <= 1'b1;
    REQ <= r;
    PC_IN <= pc;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'b0;
    n = 0;
    do
    begin
      @(negedge CLK_SYS);
      n++;
    end
    while (RES_VALID !== 1'b1 && n < 8);
    check("res_valid", RES_VALID, 1'b1);
  endtask
  task automatic t_abs();
    oag_req_t r;
    r = '0;
    r.ext = 1'b1;
    r.src_am = AM_ABS;
    r.dst_abs = 1'b1;
    r.src_ext = 4'h3;
    r.dst_ext = 4'h7;
    issue(r, 20'h2_1034);
    check("src_addr", RES.src_addr, {4'h3, ~16'h1034});
    check("dst_addr", RES.dst_addr, {4'h7, ~16'h1036});
    check("words", RES.words, 3'h4);
    $display("test absolute done");
  endtask
  task automatic t_ind();
    oag_req_t r;
    r = '0;
    r.src_am = AM_IND;
    r.src_reg = 4'h5;
    r.dst_reg = 4'h6;
    issue(r, 20'h2_1034);
    check("src_addr", RES.src_addr, 20'h5_579C);
    check("inc_we", RES.inc_we, 1'b0);
    check("dst_base", RES.dst_base, 20'h6_579C);
    $display("test indirect done");
  endtask
  task automatic t_auto();
    oag_req_t r;
    logic [19:0] st [3] = '{INC_BYTE, INC_WORD, INC_ADDR};
    for (int k = 0; k < 3; k++)
    begin
      r = '0;
      r.src_am = AM_AUTO;
      r.sz = 2'(k);
      r.src_reg = 4'hA;
      r.dst_reg = (k == 2) ? 4'hA : 4'h2;
      issue(r, 20'h2_1034);
      check("src_addr", RES.src_addr, 20'hA_579C);
      check("inc_val", RES.inc_val, 20'hA_579C + st[k]);
      check("inc_reg", RES.inc_reg, 4'hA);
      if (k == 2)
        check("dst_base", RES.dst_base, 20'hA_579C + st[k]);
    end
    $display("test autoincrement done");
  endtask
  task automatic t_imm();
    oag_req_t r;
    for (int k = 0; k < 3; k++)
    begin
      r = '0;
      r.src_am = AM_IMM;
      r.sz = SZ_ADDR;
      r.ext = (k == 1);
      r.cg = (k == 2);
      r.src_ext = 4'h2;
      r.cg_val = 20'h0_0004;
      issue(r, 20'h2_1036);
      check("is_imm", RES.src_is_imm, 1'b1);
      check("src_val", RES.src_val, (k == 2) ? 20'h0_0004
        : {(k == 1) ? 4'h2 : 4'h0, ~16'h1036});
      check("pc", RES.pc, (k == 2) ? 20'h2_1036 : 20'h2_1038);
      check("words", RES.words, (k == 1) ? 3'h3 : 3'(2 - k / 2));
    end
    $display("test immediate done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    t_abs();
    t_ind();
    t_auto();
    t_imm();
    results();
  end
  // eight requests of under twenty cycles each, with ample margin
  initial
  begin
    #20000;
    num_errors++;
    results();
  end
endmodule
bind oag_core oag_props u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .PC_IN(PC_IN),
  .REQ_READY(REQ_READY), .MEM(MEM), .RES_VALID(RES_VALID), .RES(RES));
`default_nettype wire
